// ===== dsos_pkg.sv
package dsos_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [5:0] DSOS_OFS_SELECT = 6'h00;
	localparam logic [5:0] DSOS_OFS_ZERO_THR = 6'h04;
	localparam logic [5:0] DSOS_OFS_BAND = 6'h08;
	localparam logic [5:0] DSOS_OFS_SET_SPEED = 6'h0C;
	localparam logic [5:0] DSOS_OFS_PROC_BAND = 6'h10;
	localparam logic [5:0] DSOS_OFS_POS_BAND = 6'h14;
	localparam logic [5:0] DSOS_OFS_TEMP_LIMIT = 6'h18;
	localparam logic [5:0] DSOS_OFS_PROTECT = 6'h1C;
	localparam logic [5:0] DSOS_OFS_STATUS = 6'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DSOS_SEL_WIDTH = 4;
	localparam int DSOS_NUM_OUT = 4;
	localparam int DSOS_PROT_FOLLOW_EN_BIT = 0;
	localparam int DSOS_PROT_CLEAR_BIT = 1;
	localparam int DSOS_STAT_OUT_POS = 16;
	localparam int DSOS_STAT_SHUTDOWN_BIT = 20;
	localparam int DSOS_STAT_DIR_BIT = 21;

	// ----------------------------------------------------------------
	// Output conditions
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		DSOS_COND_READY = 4'h0,
		DSOS_COND_ZERO_SPEED = 4'h1,
		DSOS_COND_AT_SPEED = 4'h2,
		DSOS_COND_AT_SET_SPEED = 4'h3,
		DSOS_COND_OVERLOAD = 4'h4,
		DSOS_COND_KEYPAD = 4'h5,
		DSOS_COND_FAULT = 4'h6,
		DSOS_COND_FOLLOW_ERR = 4'h7,
		DSOS_COND_MOTOR_DIR = 4'h8,
		DSOS_COND_DRIVE_ON = 4'h9,
		DSOS_COND_CMD_DIR = 4'hA,
		DSOS_COND_POSITION_REACHED_FLAG = 4'hB,
		DSOS_COND_TEMP_WARN = 4'hC,
		DSOS_COND_PROC_ERR = 4'hD,
		DSOS_COND_DRIVE_RUN = 4'hE
	} dsos_cond_e;
	localparam int DSOS_NUM_COND = 15;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [15:0] DSOS_RST_SELECT = 16'h6210;
	localparam logic [15:0] DSOS_RST_ZERO_THR = 16'h0000;
	localparam logic [15:0] DSOS_RST_BAND = 16'h0000;
	localparam logic [15:0] DSOS_RST_SET_SPEED = 16'h0000;
	localparam logic [15:0] DSOS_RST_PROC_BAND = 16'h0000;
	localparam logic [15:0] DSOS_RST_POS_BAND = 16'h0000;
	localparam logic [7:0] DSOS_RST_TEMP_LIMIT = 8'hFF;
	localparam logic [8:0] DSOS_TEMP_WARN_MARGIN_C = 9'h003;

endpackage

// ===== dsos_cond_if.sv
`timescale 1ns/10ps
interface dsos_cond_if;
	import dsos_pkg::*;
	logic [15:0] zero_thr, band, set_speed, proc_band, pos_band;
	logic [7:0] temp_limit, heatsink_temp;
	logic [15:0] speed_ref, speed_fb, out_freq, pos_err, proc_fb, proc_sp;
	logic power_good, fault_any, overload_fault, local_keypad, motor_dir, cmd_reverse;
	logic excitation_ok, positioning, drive_enabled, cmd_present, dir_issued;
	logic [DSOS_NUM_COND-1:0] cond;
	logic in_band;
	modport eval (
		input zero_thr, band, set_speed, proc_band, pos_band, temp_limit, heatsink_temp,
		input speed_ref, speed_fb, out_freq, pos_err, proc_fb, proc_sp,
		input power_good, fault_any, overload_fault, local_keypad, motor_dir, cmd_reverse,
		input excitation_ok, positioning, drive_enabled, cmd_present, dir_issued,
		output cond, in_band
	);
	modport ctrl (
		output zero_thr, band, set_speed, proc_band, pos_band, temp_limit, heatsink_temp,
		output speed_ref, speed_fb, out_freq, pos_err, proc_fb, proc_sp,
		output power_good, fault_any, overload_fault, local_keypad, motor_dir, cmd_reverse,
		output excitation_ok, positioning, drive_enabled, cmd_present, dir_issued,
		input cond, in_band
	);
endinterface

// ===== dsos_cond.sv
`timescale 1ns/10ps
module dsos_cond
	import dsos_pkg::*;
(
	dsos_cond_if.eval cif
);

	logic [16:0] speed_diff;
	logic [16:0] proc_diff;
	logic [8:0] temp_sum;
	logic ready;

	// Differences are taken one bit wider so that no magnitude wraps.
	always_comb begin
		speed_diff = (cif.speed_fb >= cif.speed_ref) ?
			({1'b0, cif.speed_fb} - {1'b0, cif.speed_ref}) :
			({1'b0, cif.speed_ref} - {1'b0, cif.speed_fb});
		proc_diff = (cif.proc_fb >= cif.proc_sp) ?
			({1'b0, cif.proc_fb} - {1'b0, cif.proc_sp}) :
			({1'b0, cif.proc_sp} - {1'b0, cif.proc_fb});
		temp_sum = {1'b0, cif.heatsink_temp} + DSOS_TEMP_WARN_MARGIN_C;
		ready = cif.power_good && !cif.fault_any;
		cif.in_band = speed_diff <= {1'b0, cif.band};
		cif.cond = '0;
		cif.cond[DSOS_COND_READY] = ready;
		cif.cond[DSOS_COND_ZERO_SPEED] = cif.out_freq < cif.zero_thr;
		cif.cond[DSOS_COND_AT_SPEED] = cif.in_band;
		cif.cond[DSOS_COND_AT_SET_SPEED] = cif.speed_fb >= cif.set_speed;
		cif.cond[DSOS_COND_OVERLOAD] = !cif.overload_fault;
		cif.cond[DSOS_COND_KEYPAD] = cif.local_keypad;
		cif.cond[DSOS_COND_FAULT] = cif.fault_any;
		cif.cond[DSOS_COND_FOLLOW_ERR] = !cif.in_band;
		cif.cond[DSOS_COND_MOTOR_DIR] = cif.motor_dir;
		cif.cond[DSOS_COND_DRIVE_ON] = cif.excitation_ok;
		cif.cond[DSOS_COND_CMD_DIR] = cif.cmd_reverse;
		cif.cond[DSOS_COND_POSITION_REACHED_FLAG] = cif.positioning && (cif.pos_err <= cif.pos_band);
		cif.cond[DSOS_COND_TEMP_WARN] = temp_sum >= {1'b0, cif.temp_limit};
		cif.cond[DSOS_COND_PROC_ERR] = proc_diff > {1'b0, cif.proc_band};
		cif.cond[DSOS_COND_DRIVE_RUN] = ready && cif.drive_enabled && cif.cmd_present
			&& cif.dir_issued;
	end

endmodule

// ===== dsos_top.sv
`timescale 1ns/10ps
// What this block does
// - Four outputs, each assigned any one condition.
// - Ready: powered and no fault present.
// - Zero speed: output frequency below threshold.
// - At speed: speed within tolerance band.
// - Set speed: speed at or above threshold.
// - Overload: normally closed, opens on overload fault.
// - Keypad control: drive under local keypad.
// - Fault: any drive fault present.
// - Following error: speed outside tolerance band.
// - Motor direction: high on reverse, low forward.
// - Drive on: excitation reached, torque possible.
// - Commanded direction: always valid level.
// - Position_reached_flag: positioning and error within band.
// - Temperature warning within 3 degrees of limit.
// - Process error: feedback outside setpoint band.
// - Drive run: ready, enabled, command, direction.
// - One speed band shared by three checks.
// - Following error protection shuts drive down.
module dsos_top
	import dsos_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [15:0] speed_ref,
	input wire logic [15:0] speed_fb,
	input wire logic [15:0] out_freq,
	input wire logic [15:0] pos_err,
	input wire logic [15:0] proc_fb,
	input wire logic [15:0] proc_sp,
	input wire logic [7:0] heatsink_temp,
	input wire logic power_good,
	input wire logic fault_any,
	input wire logic overload_fault,
	input wire logic local_keypad,
	input wire logic reverse_cmd,
	input wire logic forward_cmd,
	input wire logic cmd_reverse,
	input wire logic excitation_ok,
	input wire logic positioning,
	input wire logic drive_enabled,
	input wire logic cmd_present,
	input wire logic dir_issued,
	output logic [3:0] status_out,
	output logic drive_shutdown
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] sel;
		logic [15:0] zero_thr;
		logic [15:0] band;
		logic [15:0] set_speed;
		logic [15:0] proc_band;
		logic [15:0] pos_band;
		logic [7:0] temp_limit;
		logic follow_en;
		logic shutdown;
		logic motor_dir;
		logic ack;
		logic [3:0] opto;
		logic [31:0] rdata;
	} dsos_state_s;

	dsos_state_s st;
	dsos_state_s next_st;
	dsos_cond_if cif ();
	logic [3:0] mux_out;
	logic [31:0] be_mask;
	logic wr_take;
	logic rd_load;
	logic clr_req;
	logic trip;

	dsos_cond u_cond (
		.cif(cif)
	);

	assign cif.zero_thr = st.zero_thr;
	assign cif.band = st.band;
	assign cif.set_speed = st.set_speed;
	assign cif.proc_band = st.proc_band;
	assign cif.pos_band = st.pos_band;
	assign cif.temp_limit = st.temp_limit;
	assign cif.heatsink_temp = heatsink_temp;
	assign cif.speed_ref = speed_ref;
	assign cif.speed_fb = speed_fb;
	assign cif.out_freq = out_freq;
	assign cif.pos_err = pos_err;
	assign cif.proc_fb = proc_fb;
	assign cif.proc_sp = proc_sp;
	assign cif.power_good = power_good;
	assign cif.fault_any = fault_any;
	assign cif.overload_fault = overload_fault;
	assign cif.local_keypad = local_keypad;
	assign cif.motor_dir = st.motor_dir;
	assign cif.cmd_reverse = cmd_reverse;
	assign cif.excitation_ok = excitation_ok;
	assign cif.positioning = positioning;
	assign cif.drive_enabled = drive_enabled;
	assign cif.cmd_present = cmd_present;
	assign cif.dir_issued = dir_issued;

	// ----------------------------------------------------------------
	// Output selectors
	// ----------------------------------------------------------------
	// An unused selector code drives its output low rather than a stale value.
	genvar g;
	generate
		for (g = 0; g < DSOS_NUM_OUT; g++) begin : g_mux
			logic [3:0] code;
			assign code = st.sel[g*DSOS_SEL_WIDTH +: DSOS_SEL_WIDTH];
			assign mux_out[g] = (code < 4'(DSOS_NUM_COND)) ? cif.cond[code] : 1'b0;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	// Every access holds one wait cycle so read data always come from flops.
	assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
	assign avs_readdata = st.rdata;
	assign status_out = st.opto;
	assign drive_shutdown = st.shutdown;
	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wr_take = avs_write && st.ack;
	assign rd_load = avs_read && !st.ack;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [31:0] m);
		merge16 = (old & ~m[15:0]) | (wd[15:0] & m[15:0]);
	endfunction

	always_comb begin
		next_st = st;
		next_st.ack = (avs_read || avs_write) && !st.ack;
		clr_req = 1'b0;
		if (wr_take) begin
			unique case (avs_address)
				DSOS_OFS_SELECT: next_st.sel = merge16(st.sel, avs_writedata, be_mask);
				DSOS_OFS_ZERO_THR: next_st.zero_thr = merge16(st.zero_thr, avs_writedata, be_mask);
				DSOS_OFS_BAND: next_st.band = merge16(st.band, avs_writedata, be_mask);
				DSOS_OFS_SET_SPEED: next_st.set_speed = merge16(st.set_speed, avs_writedata, be_mask);
				DSOS_OFS_PROC_BAND: next_st.proc_band = merge16(st.proc_band, avs_writedata, be_mask);
				DSOS_OFS_POS_BAND: next_st.pos_band = merge16(st.pos_band, avs_writedata, be_mask);
				DSOS_OFS_TEMP_LIMIT: begin
					if (avs_byteenable[0]) begin
						next_st.temp_limit = avs_writedata[7:0];
					end
				end
				DSOS_OFS_PROTECT: begin
					if (avs_byteenable[0]) begin
						next_st.follow_en = avs_writedata[DSOS_PROT_FOLLOW_EN_BIT];
						clr_req = avs_writedata[DSOS_PROT_CLEAR_BIT];
					end
				end
				default: begin
				end
			endcase
		end
		// A trip in the same cycle as a clear request keeps the drive shut down.
		trip = st.follow_en && !cif.in_band;
		if (trip) begin
			next_st.shutdown = 1'b1;
		end else if (clr_req) begin
			next_st.shutdown = 1'b0;
		end
		// Reverse wins if both commands land together, the safer reading for a brake.
		if (reverse_cmd) begin
			next_st.motor_dir = 1'b1;
		end else if (forward_cmd) begin
			next_st.motor_dir = 1'b0;
		end
		next_st.opto = mux_out;
		if (rd_load) begin
			unique case (avs_address)
				DSOS_OFS_SELECT: next_st.rdata = {16'h0000, st.sel};
				DSOS_OFS_ZERO_THR: next_st.rdata = {16'h0000, st.zero_thr};
				DSOS_OFS_BAND: next_st.rdata = {16'h0000, st.band};
				DSOS_OFS_SET_SPEED: next_st.rdata = {16'h0000, st.set_speed};
				DSOS_OFS_PROC_BAND: next_st.rdata = {16'h0000, st.proc_band};
				DSOS_OFS_POS_BAND: next_st.rdata = {16'h0000, st.pos_band};
				DSOS_OFS_TEMP_LIMIT: next_st.rdata = {24'h00_0000, st.temp_limit};
				DSOS_OFS_PROTECT: next_st.rdata = {31'h0000_0000, st.follow_en};
				DSOS_OFS_STATUS: begin
					next_st.rdata = 32'h0000_0000;
					next_st.rdata[DSOS_NUM_COND-1:0] = cif.cond;
					next_st.rdata[DSOS_STAT_OUT_POS +: DSOS_NUM_OUT] = st.opto;
					next_st.rdata[DSOS_STAT_SHUTDOWN_BIT] = st.shutdown;
					next_st.rdata[DSOS_STAT_DIR_BIT] = st.motor_dir;
				end
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
			st.sel <= DSOS_RST_SELECT;
			st.zero_thr <= DSOS_RST_ZERO_THR;
			st.band <= DSOS_RST_BAND;
			st.set_speed <= DSOS_RST_SET_SPEED;
			st.proc_band <= DSOS_RST_PROC_BAND;
			st.pos_band <= DSOS_RST_POS_BAND;
			st.temp_limit <= DSOS_RST_TEMP_LIMIT;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking dsos_cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_rev_taken;
		(reverse_cmd && !forward_cmd) ##1 (!forward_cmd && st.sel[3:0] == DSOS_COND_MOTOR_DIR);
	endsequence

	sequence s_fwd_taken;
		(forward_cmd && !reverse_cmd) ##1 (!reverse_cmd && st.sel[3:0] == DSOS_COND_MOTOR_DIR);
	endsequence

	property p_wait_one;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");

	property p_fault_route;
		st.sel[3:0] == DSOS_COND_FAULT && fault_any |=> status_out[0];
	endproperty
	a_fault_route: assert property (p_fault_route) else $error("fault not routed");

	property p_ready_route;
		st.sel[7:4] == DSOS_COND_READY && power_good && !fault_any |=> status_out[1];
	endproperty
	a_ready_route: assert property (p_ready_route) else $error("ready not routed");

	property p_overload_open;
		st.sel[11:8] == DSOS_COND_OVERLOAD && overload_fault |=> !status_out[2];
	endproperty
	a_overload_open: assert property (p_overload_open) else $error("overload contact closed");

	property p_rev_high;
		s_rev_taken |=> status_out[0];
	endproperty
	a_rev_high: assert property (p_rev_high) else $error("direction not high on reverse");

	property p_fwd_low;
		s_fwd_taken |=> !status_out[0];
	endproperty
	a_fwd_low: assert property (p_fwd_low) else $error("direction not low on forward");

	property p_zero_speed;
		st.sel[15:12] == DSOS_COND_ZERO_SPEED && out_freq >= st.zero_thr |=> !status_out[3];
	endproperty
	a_zero_speed: assert property (p_zero_speed) else $error("zero speed above threshold");

	property p_run_gated;
		st.sel[3:0] == DSOS_COND_DRIVE_RUN && !drive_enabled |=> !status_out[0];
	endproperty
	a_run_gated: assert property (p_run_gated) else $error("run without enable");

	property p_trip;
		st.follow_en && !cif.in_band |=> drive_shutdown;
	endproperty
	a_trip: assert property (p_trip) else $error("following error did not shut down");

	property p_shutdown_holds;
		drive_shutdown && !(wr_take && avs_address == DSOS_OFS_PROTECT
			&& avs_byteenable[0] && avs_writedata[DSOS_PROT_CLEAR_BIT]) |=> drive_shutdown;
	endproperty
	a_shutdown_holds: assert property (p_shutdown_holds) else $error("shutdown dropped");

	property p_band_shared;
		st.sel[7:4] == DSOS_COND_AT_SPEED && st.sel[11:8] == DSOS_COND_FOLLOW_ERR
			|=> status_out[1] != status_out[2];
	endproperty
	a_band_shared: assert property (p_band_shared) else $error("band checks disagree");

	property p_at_speed;
		st.sel[3:0] == DSOS_COND_AT_SPEED && speed_fb >= speed_ref
			&& (speed_fb - speed_ref) <= st.band |=> status_out[0];
	endproperty
	a_at_speed: assert property (p_at_speed) else $error("at speed not shown in band");

	property p_set_speed;
		st.sel[7:4] == DSOS_COND_AT_SET_SPEED && speed_fb >= st.set_speed |=> status_out[1];
	endproperty
	a_set_speed: assert property (p_set_speed) else $error("set speed not shown");

	property p_keypad;
		st.sel[11:8] == DSOS_COND_KEYPAD && local_keypad |=> status_out[2];
	endproperty
	a_keypad: assert property (p_keypad) else $error("keypad control not shown");

	property p_follow_err;
		st.sel[15:12] == DSOS_COND_FOLLOW_ERR && speed_fb < speed_ref
			&& (speed_ref - speed_fb) > st.band |=> status_out[3];
	endproperty
	a_follow_err: assert property (p_follow_err) else $error("following error not shown");

	property p_drive_on;
		st.sel[3:0] == DSOS_COND_DRIVE_ON && !excitation_ok |=> !status_out[0];
	endproperty
	a_drive_on: assert property (p_drive_on) else $error("drive on without excitation");

	property p_cmd_dir;
		st.sel[7:4] == DSOS_COND_CMD_DIR |=> status_out[1] == $past(cmd_reverse);
	endproperty
	a_cmd_dir: assert property (p_cmd_dir) else $error("commanded direction wrong");

	property p_position_reached_flag;
		st.sel[11:8] == DSOS_COND_POSITION_REACHED_FLAG && positioning && pos_err > st.pos_band
			|=> !status_out[2];
	endproperty
	a_position_reached_flag: assert property (p_position_reached_flag) else $error("position_reached_flag outside band");

	property p_temp_warn;
		st.sel[15:12] == DSOS_COND_TEMP_WARN && st.temp_limit >= 8'(DSOS_TEMP_WARN_MARGIN_C)
			&& heatsink_temp >= (st.temp_limit - 8'(DSOS_TEMP_WARN_MARGIN_C)) |=> status_out[3];
	endproperty
	a_temp_warn: assert property (p_temp_warn) else $error("temperature warning missing");

	property p_proc_ok;
		st.sel[3:0] == DSOS_COND_PROC_ERR && proc_fb >= proc_sp
			&& (proc_fb - proc_sp) <= st.proc_band |=> !status_out[0];
	endproperty
	a_proc_ok: assert property (p_proc_ok) else $error("process error inside band");

	property p_run_full;
		st.sel[7:4] == DSOS_COND_DRIVE_RUN && power_good && !fault_any && drive_enabled
			&& cmd_present && dir_issued |=> status_out[1];
	endproperty
	a_run_full: assert property (p_run_full) else $error("run not shown");

endmodule

// ===== dsos_plant_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Plant interlock seen by the four status outputs
// ----------------------------------------------------------------
// The brake is released only while output 0 says go and no shutdown stands.
// A registered release mimics the relay delay of the real interlock.
module dsos_plant_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] status_out,
	input wire logic drive_shutdown,
	output logic brake_release
);
	always_ff @(posedge clk) begin
		if (reset) begin
			brake_release <= 1'b0;
		end else begin
			brake_release <= status_out[0] & ~drive_shutdown;
		end
	end
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Self-checking bench for the status output selector
// ----------------------------------------------------------------
module tb_top;
	import dsos_pkg::*;
	logic clk, reset, avs_read, avs_write, avs_waitrequest, drive_shutdown, brake_release;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable, status_out;
	logic [15:0] speed_ref, speed_fb, out_freq, pos_err, proc_fb, proc_sp;
	logic [7:0] heatsink_temp;
	logic power_good, fault_any, overload_fault, local_keypad, reverse_cmd, forward_cmd;
	logic cmd_reverse, excitation_ok, positioning, drive_enabled, cmd_present, dir_issued;
	int num_errors = 0;
	int samples_checked = 0;
	logic v;

	dsos_top i_dut (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .speed_ref(speed_ref),
		.speed_fb(speed_fb), .out_freq(out_freq), .pos_err(pos_err), .proc_fb(proc_fb),
		.proc_sp(proc_sp), .heatsink_temp(heatsink_temp), .power_good(power_good),
		.fault_any(fault_any), .overload_fault(overload_fault), .local_keypad(local_keypad),
		.reverse_cmd(reverse_cmd), .forward_cmd(forward_cmd), .cmd_reverse(cmd_reverse),
		.excitation_ok(excitation_ok), .positioning(positioning),
		.drive_enabled(drive_enabled), .cmd_present(cmd_present), .dir_issued(dir_issued),
		.status_out(status_out), .drive_shutdown(drive_shutdown));

	dsos_plant_model i_plant (.clk(clk), .reset(reset), .status_out(status_out),
		.drive_shutdown(drive_shutdown), .brake_release(brake_release));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One wait state is normal; only the watchdog ends a wait that never comes back.
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// Puts every plant input except reverse_cmd and forward_cmd at a neutral level.
	task automatic set_neutral();
		power_good <= 1'b1;
		fault_any <= 1'b0;
		overload_fault <= 1'b0;
		local_keypad <= 1'b0;
		speed_ref <= 16'h03E8;
		speed_fb <= 16'h03E8;
		out_freq <= 16'h03E8;
		pos_err <= 16'h0000;
		proc_fb <= 16'h00C8;
		proc_sp <= 16'h00C8;
		heatsink_temp <= 8'h14;
		excitation_ok <= 1'b0;
		positioning <= 1'b0;
		drive_enabled <= 1'b0;
		cmd_present <= 1'b0;
		dir_issued <= 1'b0;
		cmd_reverse <= 1'b0;
	endtask

	// Makes condition c show v on top of neutral plant inputs.
	task automatic set_cond(input int c, input logic v);
		set_neutral();
		case (c)
			0: fault_any <= ~v;
			1: out_freq <= v ? 16'h0063 : 16'h0064;
			2: speed_fb <= v ? 16'h03F2 : 16'h03F3;
			3: speed_fb <= v ? 16'h01F4 : 16'h01F3;
			4: overload_fault <= ~v;
			5: local_keypad <= v;
			6: fault_any <= v;
			7: speed_fb <= v ? 16'h03DD : 16'h03DE;
			8: begin
				reverse_cmd <= v;
				forward_cmd <= ~v;
			end
			9: excitation_ok <= v;
			10: cmd_reverse <= v;
			11: begin
				positioning <= 1'b1;
				pos_err <= v ? 16'h0014 : 16'h0015;
			end
			12: heatsink_temp <= v ? 8'h4D : 8'h4C;
			13: proc_fb <= v ? 16'h00CE : 16'h00CD;
			14: begin
				drive_enabled <= v;
				dir_issued <= 1'b1;
				cmd_present <= 1'b1;
			end
			default: ;
		endcase
		@(posedge clk);
		reverse_cmd <= 1'b0;
		forward_cmd <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	initial begin
		#2_000_000;
		num_errors++;
		report_and_stop();
	end

	initial begin
		reset = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		reverse_cmd = 1'b0;
		forward_cmd = 1'b0;
		set_neutral();
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// Reset selectors: ready, zero speed, at speed, fault.
		@(negedge clk);
		check("status after reset", {28'h0, status_out}, 32'h0000_0005);
		bus(1'b0, DSOS_OFS_SELECT, 32'h0);
		check("select reset", rd, {16'h0, DSOS_RST_SELECT});
		bus(1'b0, DSOS_OFS_TEMP_LIMIT, 32'h0);
		check("temp limit reset", rd, {24'h0, DSOS_RST_TEMP_LIMIT});
		bus(1'b0, 6'h3C, 32'h0);
		check("unmapped read", rd, 32'h0000_0000);
		$display("test reset done");
		bus(1'b1, DSOS_OFS_ZERO_THR, 32'h0000_0064);
		bus(1'b1, DSOS_OFS_BAND, 32'h0000_000A);
		bus(1'b1, DSOS_OFS_SET_SPEED, 32'h0000_01F4);
		bus(1'b1, DSOS_OFS_PROC_BAND, 32'h0000_0005);
		bus(1'b1, DSOS_OFS_POS_BAND, 32'h0000_0014);
		bus(1'b1, DSOS_OFS_TEMP_LIMIT, 32'h0000_0050);
		for (int c = 0; c < 16; c++) begin
			bus(1'b1, DSOS_OFS_SELECT, {16'h0, {4{c[3:0]}}});
			for (int k = 0; k < 2; k++) begin
				v = (k == 0) && (c != 15);
				set_cond(c, v);
				check($sformatf("output code %0d", c), {28'h0, status_out}, {28'h0, {4{v}}});
			end
		end
		$display("test conditions done");
		// Follow-error trip: none while disabled, latched once enabled, then cleared.
		bus(1'b1, DSOS_OFS_SELECT, 32'h0000_7720);
		set_cond(7, 1'b1);
		check("no trip while disabled", {31'h0, drive_shutdown}, 32'h0);
		bus(1'b1, DSOS_OFS_PROTECT, 32'h0000_0001);
		repeat (2) @(posedge clk);
		check("trip", {31'h0, drive_shutdown}, 32'h1);
		set_cond(7, 1'b0);
		check("trip held", {31'h0, drive_shutdown}, 32'h1);
		check("shared band", {28'h0, status_out}, 32'h0000_0003);
		bus(1'b0, DSOS_OFS_STATUS, 32'h0);
		check("status shutdown bit", {31'h0, rd[DSOS_STAT_SHUTDOWN_BIT]}, 32'h1);
		bus(1'b1, DSOS_OFS_PROTECT, 32'h0000_0003);
		repeat (2) @(posedge clk);
		check("trip cleared", {31'h0, drive_shutdown}, 32'h0);
		check("brake released", {31'h0, brake_release}, 32'h1);
		$display("test protection done");
		report_and_stop();
	end
endmodule
